// ==== core/dsae_engine.sv ====
// Decorated store AND/OR engine between the core bus master and a crossbar port.
//
// Summary of operation
// - Decorated AND store reads target, ANDs with store data, writes result atomically.
// - Decorated OR store reads target, ORs with store data, writes result atomically.
// - Operand size follows the store size; read and write-back use it.
// - Address bits 30:29 select space: 01 RAM, 10 peripheral.
// - Address bits 28:26 equal 001 select the AND store.
// - Address bits 28:26 equal 010 select the OR store.
// - Target is low twenty address bits added to the space base.
// - Don't-care address bits are ignored in decode and target forming.
// - First cycle drives real address as a read and captures attributes.
// - Second cycle reissues captured address as write while read completes.
// - AND result is captured during the second-cycle data phase.
// - OR result is captured during the second-cycle data phase.
// - Third cycle drives the result register onto downstream write data.
// - Master is stalled during the second cycle; slave wait states pass through otherwise.
// - Decoration bits are stripped before the address goes downstream.
// - Non-decorated accesses pass through combinationally without extra stages.
`timescale 1ns/10ps
module dsae_engine (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [31:0] hAddrUp,
    input wire logic [1:0] hTransUp,
    input wire logic hWriteUp,
    input wire logic [2:0] hSizeUp,
    input wire logic [31:0] hWdataUp,
    output logic hReadyUp,
    output logic [31:0] hRdataUp,
    output logic hRespUp,
    output logic [31:0] hAddrDn,
    output logic [1:0] hTransDn,
    output logic hWriteDn,
    output logic [2:0] hSizeDn,
    output logic [31:0] hWdataDn,
    input wire logic hReadyDn,
    input wire logic [31:0] hRdataDn,
    input wire logic hRespDn
);
    typedef struct packed {
        dsae_pkg::dsae_state_e state;
        logic [31:0] addr;
        logic [2:0] size;
        logic opAnd;
    } dsae_engine_s;

    dsae_engine_s st_q;
    dsae_engine_s st_d;
    dsae_merge_if mrg ();

    logic [1:0] space;
    logic [2:0] opCode;
    logic spaceOk;
    logic opOk;
    logic decorated;
    logic taken;
    logic [31:0] base;
    logic [31:0] target;

    // Only the top bit, space, operation and offset fields are looked at; the rest are don't-care.
    assign space = hAddrUp[dsae_pkg::SPACE_HI:dsae_pkg::SPACE_LO];
    assign opCode = hAddrUp[dsae_pkg::OP_HI:dsae_pkg::OP_LO];
    assign spaceOk = (space == dsae_pkg::SPACE_RAM) || (space == dsae_pkg::SPACE_PERIPH);
    assign opOk = (opCode == dsae_pkg::OP_AND) || (opCode == dsae_pkg::OP_OR);
    assign decorated = !hAddrUp[dsae_pkg::TOP_BIT] && spaceOk && opOk
        && hWriteUp && hTransUp[1];
    assign base = (space == dsae_pkg::SPACE_RAM) ? dsae_pkg::BASE_RAM : dsae_pkg::BASE_PERIPH;
    assign target = base + {12'h000, hAddrUp[dsae_pkg::OFFSET_W-1:0]};

    // An address phase is accepted only when the previous data phase finishes.
    assign taken = decorated && hReadyDn && (st_q.state != dsae_pkg::ST_READ);

    always_comb begin
        st_d = st_q;
        case (st_q.state)
            dsae_pkg::ST_PASS, dsae_pkg::ST_WRITE: begin
                if (taken) begin
                    st_d.state = dsae_pkg::ST_READ;
                    st_d.addr = target;
                    st_d.size = hSizeUp;
                    st_d.opAnd = (opCode == dsae_pkg::OP_AND);
                end else if (hReadyDn) begin
                    st_d.state = dsae_pkg::ST_PASS;
                end
            end
            dsae_pkg::ST_READ: begin
                // The write address phase is held until the read data phase is accepted.
                if (hReadyDn) begin
                    st_d.state = dsae_pkg::ST_WRITE;
                end
            end
            default: begin
                st_d.state = dsae_pkg::ST_PASS;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= '{state: dsae_pkg::ST_PASS, addr: dsae_pkg::RST_ADDR,
                      size: dsae_pkg::RST_SIZE, opAnd: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign mrg.capture = (st_q.state == dsae_pkg::ST_READ) && hReadyDn;
    assign mrg.opAnd = st_q.opAnd;
    assign mrg.readData = hRdataDn;
    // Lane replication by the master lets the full word be combined regardless of size.
    assign mrg.writeData = hWdataUp;

    dsae_merge u_merge (
        .ref_clk(ref_clk),
        .rst(rst),
        .mrg(mrg)
    );

    // Pass-through must stay combinational to add no latency, so these outputs are muxes.
    always_comb begin
        hAddrDn = hAddrUp;
        hTransDn = hTransUp;
        hWriteDn = hWriteUp;
        hSizeDn = hSizeUp;
        hWdataDn = hWdataUp;
        hReadyUp = hReadyDn;
        hRdataUp = hRdataDn;
        hRespUp = hRespDn;
        if (st_q.state == dsae_pkg::ST_READ) begin
            hAddrDn = st_q.addr;
            hTransDn = dsae_pkg::TRANS_NONSEQ;
            hWriteDn = 1'b1;
            hSizeDn = st_q.size;
            hReadyUp = 1'b0;
            hRespUp = 1'b0;
        end else if (decorated) begin
            // Stripped even while the slave stalls, so no slave ever sees a decoration.
            hAddrDn = target;
            hWriteDn = 1'b0;
        end
        if (st_q.state == dsae_pkg::ST_WRITE) begin
            hWdataDn = mrg.result;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    logic inRead;
    logic inWrite;
    assign inRead = (st_q.state == dsae_pkg::ST_READ);
    assign inWrite = (st_q.state == dsae_pkg::ST_WRITE);

    sequence seq_taken;
        taken && !inRead;
    endsequence
    sequence seq_read_done;
        inRead && hReadyDn;
    endsequence

    read_conv_a: assert property (seq_taken |-> !hWriteDn && hAddrDn == target)
        else $error("decorated store not turned into a read of the real address");
    write_reissue_a: assert property (seq_taken |=> hWriteDn && hAddrDn == $past(target))
        else $error("captured address not reissued as a write");
    size_keep_a: assert property (seq_taken |=> hSizeDn == $past(hSizeUp))
        else $error("write-back size differs from store size");
    strip_top_a: assert property (seq_taken |-> hAddrDn[28:20] == 9'h000)
        else $error("decoration bits reached the downstream address");
    stall_up_a: assert property (inRead |-> !hReadyUp)
        else $error("master not stalled during the read phase");
    wait_pass_a: assert property (inWrite |-> hReadyUp == hReadyDn)
        else $error("slave wait state not passed to the master");
    and_result_a: assert property (seq_read_done and mrg.opAnd
        |=> mrg.result == ($past(hRdataDn) & $past(hWdataUp)))
        else $error("AND result wrong");
    or_result_a: assert property (seq_read_done and !mrg.opAnd
        |=> mrg.result == ($past(hRdataDn) | $past(hWdataUp)))
        else $error("OR result wrong");
    wb_data_a: assert property (inWrite |-> hWdataDn == mrg.result)
        else $error("write-back data not the result register");
    atomic_seq_a: assert property (seq_taken ##1 seq_read_done |=> inWrite)
        else $error("read and write-back were split");
    pass_thru_a: assert property (!inRead && !decorated
        |-> hAddrDn == hAddrUp && hWriteDn == hWriteUp && hTransDn == hTransUp)
        else $error("plain access altered on its way downstream");
    top_bit_a: assert property (hAddrUp[31] |-> !decorated)
        else $error("access with bit 31 set treated as decorated");

    // Slave wait states must freeze the sequence in place rather than skip a step.
    sequence seq_read_wait;
        inRead && !hReadyDn;
    endsequence
    sequence seq_write_wait;
        inWrite && !hReadyDn;
    endsequence

    op_and_dec_a: assert property (taken && opCode == dsae_pkg::OP_AND |=> mrg.opAnd)
        else $error("AND operation code not decoded");
    op_or_dec_a: assert property (taken && opCode == dsae_pkg::OP_OR |=> !mrg.opAnd)
        else $error("OR operation code not decoded");
    ram_target_a: assert property (taken && space == dsae_pkg::SPACE_RAM
        |-> hAddrDn == (dsae_pkg::BASE_RAM | {12'h000, hAddrUp[19:0]}))
        else $error("RAM space target address wrong");
    periph_target_a: assert property (taken && space == dsae_pkg::SPACE_PERIPH
        |-> hAddrDn == (dsae_pkg::BASE_PERIPH | {12'h000, hAddrUp[19:0]}))
        else $error("peripheral space target address wrong");
    read_trans_a: assert property (inRead |-> hTransDn == dsae_pkg::TRANS_NONSEQ)
        else $error("write-back address phase not a non-sequential transfer");
    read_hold_a: assert property (seq_read_wait |=> inRead && $stable(hAddrDn))
        else $error("write address phase moved during a read wait state");
    wb_hold_a: assert property (seq_write_wait |=> inWrite && $stable(hWdataDn))
        else $error("write-back data moved during a slave wait state");
    plain_data_a: assert property (!inRead && !inWrite
        |-> hWdataDn == hWdataUp && hSizeDn == hSizeUp)
        else $error("plain access data or size altered on its way downstream");
    plain_resp_a: assert property (!inRead
        |-> hRdataUp == hRdataDn && hRespUp == hRespDn)
        else $error("slave answer altered on its way to the master");
endmodule : dsae_engine

// ==== pkg/dsae_pkg.sv ====
// Constants and types shared by the decorated store AND/OR engine.
package dsae_pkg;
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    // Decoration field positions in the upstream address.
    localparam int TOP_BIT = 31;
    localparam int SPACE_HI = 30;
    localparam int SPACE_LO = 29;
    localparam int OP_HI = 28;
    localparam int OP_LO = 26;
    localparam int OFFSET_W = 20;
    localparam logic [1:0] SPACE_RAM = 2'h1;
    localparam logic [1:0] SPACE_PERIPH = 2'h2;
    localparam logic [2:0] OP_AND = 3'h1;
    localparam logic [2:0] OP_OR = 3'h2;
    localparam logic [31:0] BASE_RAM = 32'h2000_0000;
    localparam logic [31:0] BASE_PERIPH = 32'h4000_0000;
    // Transfer type encodings of the system bus.
    localparam logic [1:0] TRANS_IDLE = 2'h0;
    localparam logic [1:0] TRANS_NONSEQ = 2'h2;
    // Values after reset.
    localparam logic [31:0] RST_ADDR = 32'h0000_0000;
    localparam logic [2:0] RST_SIZE = 3'h0;
    localparam logic [31:0] RST_RESULT = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_PASS,
        ST_READ,
        ST_WRITE
    } dsae_state_e;
endpackage : dsae_pkg

// ==== pkg/dsae_merge_if.sv ====
// Carrier between the engine sequencer and its read-modify unit.
`timescale 1ns/10ps
interface dsae_merge_if;
    logic capture;
    logic opAnd;
    logic [31:0] readData;
    logic [31:0] writeData;
    logic [31:0] result;
    modport seq (output capture, output opAnd, output readData, output writeData, input result);
    modport unit (input capture, input opAnd, input readData, input writeData, output result);
endinterface : dsae_merge_if

// ==== core/dsae_merge.sv ====
// Read-modify unit: combines read data with store data into the result register.
`timescale 1ns/10ps
module dsae_merge (
    input wire logic ref_clk,
    input wire logic rst,
    dsae_merge_if.unit mrg
);
    typedef struct packed {
        logic [31:0] result;
    } dsae_merge_s;

    dsae_merge_s st_q;
    dsae_merge_s st_d;

    always_comb begin
        st_d = st_q;
        if (mrg.capture) begin
            if (mrg.opAnd) begin
                st_d.result = mrg.readData & mrg.writeData;
            end else begin
                st_d.result = mrg.readData | mrg.writeData;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_q <= '{result: dsae_pkg::RST_RESULT};
        end else begin
            st_q <= st_d;
        end
    end

    assign mrg.result = st_q.result;
endmodule : dsae_merge

// ==== sim/dsae_slave_model.sv ====
// Downstream memory slave model that can stretch a data phase by one wait state.
`timescale 1ns/10ps
module dsae_slave_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic waitEn,
    input wire logic [31:0] hAddr,
    input wire logic [1:0] hTrans,
    input wire logic hWrite,
    input wire logic [2:0] hSize,
    input wire logic [31:0] hWdata,
    output logic hReady,
    output logic [31:0] hRdata,
    output logic hResp,
    output logic wrDone,
    output logic [31:0] wrAddr,
    output logic [31:0] wrData,
    output logic [2:0] wrSize
);
    logic [31:0] mem [256];
    logic phase;
    logic isWr;
    logic stall;
    logic [31:0] addr;
    logic [2:0] size;
    assign hReady = !(phase && stall);
    assign hResp = 1'b0;
    // Read data is only valid in a ready read data phase; otherwise it inverts on every clock edge.
    assign hRdata = (phase && !isWr && !stall) ? mem[addr[9:2]] : wrData ^ {32{ref_clk}};
    // Whole words are stored; lane selection by size is left to the size comparison.
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase <= 1'b0;
            stall <= 1'b0;
            wrDone <= 1'b0;
        end else if (hReady) begin
            phase <= hTrans[1];
            isWr <= hWrite;
            addr <= hAddr;
            size <= hSize;
            stall <= waitEn;
            wrDone <= phase && isWr;
            wrAddr <= addr;
            wrData <= hWdata;
            wrSize <= size;
            if (phase && isWr) mem[addr[9:2]] <= hWdata;
        end else begin
            stall <= 1'b0;
            wrDone <= 1'b0;
        end
    end
endmodule : dsae_slave_model

// ==== sim/test_decorated_store_and_or_engine.sv ====
// Self-checking bench for the decorated store AND/OR engine.
`timescale 1ns/10ps
module test_decorated_store_and_or_engine;
    logic ref_clk, rst, waitEn, hWriteUp, hReadyUp, hRespUp, hWriteDn, hReadyDn, hRespDn;
    logic [31:0] hAddrUp, hWdataUp, hRdataUp, hAddrDn, hWdataDn, hRdataDn, wrAddr, wrData;
    logic [1:0] hTransUp, hTransDn;
    logic [2:0] hSizeUp, hSizeDn, wrSize;
    logic wrDone, rdPhase;
    logic [31:0] shadow [16];
    logic [31:0] qa[$], qd[$], qr[$];
    logic [2:0] qs[$];
    int seed, err_total, n_compared;
    dsae_engine i_dut (.ref_clk, .rst, .hAddrUp, .hTransUp, .hWriteUp, .hSizeUp, .hWdataUp,
        .hReadyUp, .hRdataUp, .hRespUp, .hAddrDn, .hTransDn, .hWriteDn, .hSizeDn, .hWdataDn,
        .hReadyDn, .hRdataDn, .hRespDn);
    dsae_slave_model i_slave (.ref_clk(ref_clk), .rst(rst), .waitEn(waitEn), .hAddr(hAddrDn),
        .hTrans(hTransDn), .hWrite(hWriteDn), .hSize(hSizeDn), .hWdata(hWdataDn),
        .hReady(hReadyDn), .hRdata(hRdataDn), .hResp(hRespDn), .wrDone(wrDone),
        .wrAddr(wrAddr), .wrData(wrData), .wrSize(wrSize));
    always #25 ref_clk = ~ref_clk;
    task automatic chk32(input string what, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h seen %h", what, e, g);
        end
    endtask : chk32
    task automatic chk3(input string what, input logic [2:0] e, input logic [2:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h seen %h", what, e, g);
        end
    endtask : chk3
    // Waits for an edge with ready high, sampled at the falling edge to avoid races.
    task automatic wait_ready;
        logic r;
        r = 1'b0;
        for (int n = 0; n < 40 && !r; n++) begin
            @(negedge ref_clk);
            r = hReadyUp;
            @(posedge ref_clk);
        end
        if (!r) begin
            err_total++;
            $display("BAD ready exp 1 seen 0");
        end
        #1;
    endtask : wait_ready
    task automatic store(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] d,
                         input logic [31:0] ta, input logic [31:0] td);
        qa.push_back(ta);
        qd.push_back(td);
        qs.push_back(sz);
        hAddrUp = a;
        hSizeUp = sz;
        hTransUp = 2'h2;
        hWriteUp = 1'b1;
        wait_ready();
        hTransUp = 2'h0;
        hWdataUp = d;
        wait_ready();
    endtask : store
    // Plain word read; the watcher compares the data phase answer against the note.
    task automatic load(input logic [31:0] a, input logic [31:0] e);
        qr.push_back(e);
        hAddrUp = a;
        hSizeUp = 3'h2;
        hTransUp = 2'h2;
        hWriteUp = 1'b0;
        wait_ready();
        hTransUp = 2'h0;
        rdPhase = 1'b1;
        wait_ready();
        rdPhase = 1'b0;
    endtask : load
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop
    always @(negedge ref_clk) begin
        if (wrDone === 1'b1) begin
            if (qa.size() == 0) begin
                err_total++;
                $display("BAD write exp none seen %h", wrAddr);
            end else begin
                chk32("addr", qa.pop_front(), wrAddr);
                chk32("data", qd.pop_front(), wrData);
                chk3("size", qs.pop_front(), wrSize);
            end
        end
        if (rdPhase === 1'b1 && hReadyUp === 1'b1 && qr.size() > 0) begin
            chk32("rdata", qr.pop_front(), hRdataUp);
            chk32("resp", 32'h0, {31'h0, hRespUp});
        end
    end
    initial begin
        #1000000;
        err_total++;
        report_and_stop();
    end
    initial begin
        logic [31:0] a, d, e, t, r;
        logic [2:0] sz;
        seed = 96753;
        ref_clk = 1'b0;
        rst = 1'b1;
        waitEn = 1'b0;
        rdPhase = 1'b0;
        hAddrUp = 32'h0;
        hTransUp = 2'h0;
        hWriteUp = 1'b0;
        hSizeUp = 3'h2;
        hWdataUp = 32'h0;
        repeat (2) @(posedge ref_clk);
        #1 rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            shadow[i] = d;
            store(32'h2000_0000 + 32'(i * 4), 3'h2, d, 32'h2000_0000 + 32'(i * 4), d);
        end
        for (int k = 0; k < 64; k++) begin
            r = $random(seed);
            d = $random(seed);
            sz = 3'(k % 3);
            d = (sz == 3'h0) ? {4{d[7:0]}} : (sz == 3'h1) ? {2{d[15:0]}} : d;
            a = {1'b0, k[0] ? dsae_pkg::SPACE_RAM : dsae_pkg::SPACE_PERIPH,
                 k[1] ? dsae_pkg::OP_AND : dsae_pkg::OP_OR, r[31:26], r[9:0], 4'h0, r[13:10],
                 2'h0};
            t = (k[0] ? dsae_pkg::BASE_RAM : dsae_pkg::BASE_PERIPH) + {12'h0, a[19:0]};
            e = k[1] ? (shadow[r[13:10]] & d) : (shadow[r[13:10]] | d);
            if (k % 8 == 7) a[31] = 1'b1;
            if (k % 8 == 6) a[30:29] = 2'h3;
            if (k % 8 >= 6) begin
                t = a;
                e = d;
            end
            shadow[r[13:10]] = e;
            waitEn = r[14];
            store(a, sz, d, t, e);
        end
        repeat (4) @(posedge ref_clk);
        chk32("pending", 32'h0, 32'(qa.size()));
        #1;
        for (int i = 0; i < 16; i++) begin
            load(32'h2000_0000 + 32'(i * 4), shadow[i]);
        end
        report_and_stop();
    end
endmodule : test_decorated_store_and_or_engine
